/* File: src/gptp_pkg.sv */
// Purpose: Shared constants and types of the general purpose timer pair.
// Assumes: One system clock, configuration supplied on plain ports.
// Notes:   Every offset-free figure of the block lives here once.
package gptp_pkg;

    // ----------------------------------------------------------------
    // Configuration and mode encodings
    // ----------------------------------------------------------------
    localparam logic [2:0]  CFG_CHAINED   = 3'h0;          // 32-bit one-shot/periodic
    localparam logic [2:0]  CFG_CLOCK     = 3'h1;          // 32-bit real-time clock
    localparam logic [2:0]  CFG_SPLIT     = 3'h4;          // Two 16-bit timers
    localparam logic [1:0]  MODE_ONESHOT  = 2'h1;          // Counter mode field: one-shot
    localparam logic [1:0]  MODE_PERIODIC = 2'h2;          // Counter mode field: periodic

    // ----------------------------------------------------------------
    // Reset and load values
    // ----------------------------------------------------------------
    localparam logic [15:0] HALF_LOAD_RST  = 16'hFFFF;     // Load and count halves
    localparam logic [7:0]  PRESCALE_RST   = 8'h00;        // Prescale registers
    localparam logic [31:0] MATCH_RST      = 32'h0000_0000; // Match register
    localparam logic [31:0] CLOCK_FIRST    = 32'h0000_0001; // First clock-mode load
    localparam logic [31:0] COUNT32_ZERO   = 32'h0000_0000; // Terminal / rollover value

    // ----------------------------------------------------------------
    // Timing: clock-mode input divided down to one step per second
    // ----------------------------------------------------------------
    localparam int RTC_INPUT_HZ = 32768;                   // Even capture pin rate
    localparam int RTC_TICK_HZ  = 1;                       // Counter increment rate
    localparam int RTC_DIVIDE   = RTC_INPUT_HZ / RTC_TICK_HZ; // Input edges per step

    // Operating mode, Gray coded along idle -> chained -> clock -> split
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_CHAIN = 2'b01,
        OP_CLOCK = 2'b11,
        OP_SPLIT = 2'b10
    } gptp_op_e;

    // Decode of the configuration register, used only by the timer pair top
    function automatic gptp_op_e gptp_decode(input logic [2:0] cfg);
        gptp_op_e op;
        op = OP_IDLE;
        if (cfg == CFG_CHAINED) begin
            op = OP_CHAIN;
        end else if (cfg == CFG_CLOCK) begin
            op = OP_CLOCK;
        end else if (cfg == CFG_SPLIT) begin
            op = OP_SPLIT;
        end
        return op;
    endfunction

endpackage

/* File: src/gptp_half_if.sv */
// Purpose: Carrier between the timer pair top and one 16-bit half counter.
// Assumes: All signals on clk_sys.
// Notes:   Top drives control, the half drives count and time-out.
`timescale 1ns/100ps
`default_nettype none
interface gptp_half_if;
    logic        run;         // Count this cycle (enabled, split mode, not stalled)
    logic        loadWrite;   // Software rewrote the interval load
    logic [15:0] loadValue;   // Interval load value
    logic [7:0]  prescale;    // Programmed prescale value
    logic [15:0] count;       // Current count
    logic        timeout;     // Zero reached, reload taking place

    modport ctrl (output run, output loadWrite, output loadValue, output prescale,
                  input count, input timeout);
    modport unit (input run, input loadWrite, input loadValue, input prescale,
                  output count, output timeout);
endinterface
`default_nettype wire

/* File: src/gptp_half_counter.sv */
// Purpose: One 16-bit down-counter with 8-bit prescaler for split mode.
// Assumes: Top gates run with enable, mode and debug stall.
// Notes:   Time-out is a combinational pulse the top registers.
`timescale 1ns/100ps
`default_nettype none
module gptp_half_counter
    import gptp_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   reset,
    gptp_half_if.unit   bus
);

    logic [15:0] count_q;     // Count value
    logic [15:0] count_d;
    logic [7:0]  pre_q;       // Prescale down-counter
    logic [7:0]  pre_d;
    logic        timeout;     // Zero reached this step

    // ------------------------------------------------------------
    // Next count and prescaler
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        pre_d   = pre_q;
        timeout = 1'b0;
        if (bus.loadWrite) begin
            count_d = bus.loadValue;
            pre_d   = bus.prescale;
        end else if (bus.run) begin
            if (pre_q == 8'h00) begin
                pre_d = bus.prescale;
                if (count_q == 16'h0000) begin
                    count_d = bus.loadValue;
                    timeout = 1'b1;
                end else begin
                    count_d = count_q - 16'h0001;
                end
            end else begin
                pre_d = pre_q - 8'h01;
            end
        end
    end

    // Register only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_q <= HALF_LOAD_RST;
            pre_q   <= PRESCALE_RST;
        end else begin
            count_q <= count_d;
            pre_q   <= pre_d;
        end
    end

    assign bus.count   = count_q;
    assign bus.timeout = timeout;

endmodule
`default_nettype wire

/* File: src/gptp_rtc_divider.sv */
// Purpose: Divide the even capture pin clock down to a one-second step.
// Assumes: Pin is asynchronous and far slower than clk_sys.
// Notes:   Counts rising edges, so pin highs must span two system clocks.
`timescale 1ns/100ps
`default_nettype none
module gptp_rtc_divider
    import gptp_pkg::*;
#(
    parameter int DIVIDE = RTC_DIVIDE   // Input edges per step
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic capturePinEven,   // Slow clock on the even pin
    output logic      secondTick        // One-cycle step pulse
);

    localparam int CW = $clog2(DIVIDE + 1);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    logic          sync1_q;      // First synchroniser stage, read only by sync2
    logic          sync2_q;      // Second synchroniser stage
    logic          prev_q;       // Delayed copy for edge detection
    logic [CW-1:0] edges_q;      // Edges seen in this second
    logic [CW-1:0] edges_d;
    logic          tick_q;
    logic          tick_d;

    // ------------------------------------------------------------
    // Edge count toward one step
    // ------------------------------------------------------------
    always_comb begin
        edges_d = edges_q;
        tick_d  = 1'b0;
        if (sync2_q && !prev_q) begin
            if (edges_q == LAST) begin
                edges_d = '0;
                tick_d  = 1'b1;
            end else begin
                edges_d = edges_q + CW'(1);
            end
        end
    end

    // Register only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            edges_q <= '0;
            tick_q  <= 1'b0;
        end else begin
            sync1_q <= capturePinEven;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            edges_q <= edges_d;
            tick_q  <= tick_d;
        end
    end

    assign secondTick = tick_q;

endmodule
`default_nettype wire

/* File: src/gptp_timer_pair.sv */
// Purpose: General purpose timer pair: chained 32-bit, clock, or split 16-bit.
// Assumes: Software state arrives on plain ports; write strobes are pulses.
// Notes:   Counter, status and trigger outputs are all registered.
`timescale 1ns/100ps
`default_nettype none
module gptp_timer_pair
    import gptp_pkg::*;
#(
    parameter int RTC_EDGES = RTC_DIVIDE          // Pin edges per clock-mode step
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [2:0]  timerConfiguration,  // Configuration register
    input  wire logic [1:0]  aModeField,          // A counter mode field
    input  wire logic [1:0]  bModeField,          // B counter mode field
    input  wire logic        aEnableWrite,        // Pulse: software writes A enable
    input  wire logic        aEnableData,
    input  wire logic        bEnableWrite,        // Pulse: software writes B enable
    input  wire logic        bEnableData,
    input  wire logic        aIntervalWrite,      // Pulse: A interval load write
    input  wire logic [31:0] aIntervalData,
    input  wire logic        bIntervalWrite,      // Pulse: B interval load write
    input  wire logic [15:0] bIntervalData,
    input  wire logic        aPrescaleWrite,      // Pulse: A prescale write
    input  wire logic        bPrescaleWrite,      // Pulse: B prescale write
    input  wire logic [7:0]  prescaleData,
    input  wire logic        aMatchWrite,         // Pulse: A match write
    input  wire logic [31:0] aMatchData,
    input  wire logic        aOutputTriggerEnable,
    input  wire logic        bOutputTriggerEnable,
    input  wire logic        aDebugStall,
    input  wire logic        bDebugStall,
    input  wire logic        clockModeEnable,
    input  wire logic        aTimeoutMask,
    input  wire logic        bTimeoutMask,
    input  wire logic        clockMatchMask,
    input  wire logic        aTimeoutClear,       // Pulse: clear A time-out
    input  wire logic        bTimeoutClear,       // Pulse: clear B time-out
    input  wire logic        clockMatchClear,     // Pulse: clear clock match
    input  wire logic        cpuHalted,           // Debugger halt, same clock
    input  wire logic        capturePinEven,      // Asynchronous 32.768 kHz pin
    output logic [31:0]      aCounterValue,       // A counter-value read data
    output logic [15:0]      bCounterValue,       // B counter-value read data
    output logic             aEnable,
    output logic             bEnable,
    output logic             aTimeoutRaw,
    output logic             bTimeoutRaw,
    output logic             clockMatchRaw,
    output logic             aTimeoutMasked,
    output logic             bTimeoutMasked,
    output logic             clockMatchMasked,
    output logic             interruptOut,
    output logic             adcTrigger           // One-cycle trigger pulse
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    gptp_op_e    op;                   // Decoded operating mode
    logic        chained;              // Either 32-bit mode
    logic [2:0]  prevCfg_q;            // Config of last cycle, spots first selection
    logic        aEn_q, aEn_d;         // A enable, hardware may clear
    logic        bEn_q, bEn_d;         // B enable
    logic [15:0] aLoad_q, aLoad_d;     // A interval load
    logic [15:0] bLoad_q, bLoad_d;     // B interval load
    logic [7:0]  aPre_q, aPre_d;       // A prescale
    logic [7:0]  bPre_q, bPre_d;       // B prescale
    logic [31:0] match_q, match_d;     // A match value
    logic [31:0] cnt32_q, cnt32_d;     // Chained count
    logic        aRaw_q, aRaw_d;       // Sticky A time-out
    logic        bRaw_q, bRaw_d;       // Sticky B time-out
    logic        mRaw_q, mRaw_d;       // Sticky clock match
    logic        aMis_q, bMis_q, mMis_q;
    logic        irq_q, trig_q, trig_d;
    logic [31:0] aVal_q, aVal_d;       // Registered read views
    logic [15:0] bVal_q;
    logic        tick;                 // One-second step
    logic        aTimeout;             // A (or chained) zero event
    logic        bTimeout;             // B zero event
    logic        matchHit;             // Clock mode match event
    logic        aFrozen, bFrozen;     // Debug stall in force
    logic        chainTimeout;

    gptp_half_if halfA ();
    gptp_half_if halfB ();

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    gptp_half_counter uHalfA (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (halfA)
    );

    gptp_half_counter uHalfB (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (halfB)
    );

    gptp_rtc_divider #(
        .DIVIDE (RTC_EDGES)
    ) uDivider (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .capturePinEven (capturePinEven),
        .secondTick     (tick)
    );

    // ------------------------------------------------------------
    // Mode decode and stall
    // ------------------------------------------------------------
    // Select 32-bit modes
    assign op      = gptp_decode(timerConfiguration);
    assign chained = (op == OP_CHAIN) || (op == OP_CLOCK);

    assign aFrozen = cpuHalted && !clockModeEnable &&
                     (aDebugStall || ((op == OP_CLOCK) && bDebugStall));
    assign bFrozen = cpuHalted && bDebugStall;

    // ------------------------------------------------------------
    // Half counter controls, split mode only
    // ------------------------------------------------------------
    // Independent halves at config 4
    assign halfA.run       = (op == OP_SPLIT) && aEn_q && !aFrozen;
    assign halfB.run       = (op == OP_SPLIT) && bEn_q && !bFrozen;
    assign halfA.loadWrite = (op == OP_SPLIT) && aIntervalWrite;
    assign halfB.loadWrite = (op == OP_SPLIT) && bIntervalWrite;
    assign halfA.loadValue = aLoad_d;
    assign halfB.loadValue = bLoad_d;
    assign halfA.prescale  = aPre_q;
    assign halfB.prescale  = bPre_q;

    // ------------------------------------------------------------
    // Software registers: loads, prescales, match
    // ------------------------------------------------------------
    always_comb begin
        aLoad_d = aLoad_q;
        bLoad_d = bLoad_q;
        aPre_d  = aPrescaleWrite ? prescaleData : aPre_q;
        bPre_d  = bPrescaleWrite ? prescaleData : bPre_q;
        match_d = aMatchWrite ? aMatchData : match_q;
        if (aIntervalWrite) begin
            aLoad_d = aIntervalData[15:0];
            if (chained) begin
                bLoad_d = aIntervalData[31:16];
            end
        end
        if (bIntervalWrite && !chained) begin
            bLoad_d = bIntervalData;
        end
    end

    // ------------------------------------------------------------
    // Chained 32-bit counter: down count or clock mode
    // ------------------------------------------------------------
    always_comb begin
        cnt32_d      = cnt32_q;
        chainTimeout = 1'b0;
        matchHit     = 1'b0;
        if (op == OP_CLOCK) begin
            if (prevCfg_q != CFG_CLOCK) begin
                cnt32_d = CLOCK_FIRST;
            end else if (aMatchWrite && !aEn_q) begin
                cnt32_d = aMatchData;
            end else if (aEn_q && !aFrozen && tick) begin
                if (cnt32_q == match_q) begin
                    cnt32_d  = COUNT32_ZERO;
                    matchHit = 1'b1;
                end else begin
                    cnt32_d = cnt32_q + 32'h0000_0001;
                end
            end
        end else if (op == OP_CHAIN) begin
            if (aIntervalWrite) begin
                cnt32_d = aIntervalData;
            end else if (aEn_q && !aFrozen) begin
                if (cnt32_q == COUNT32_ZERO) begin
                    cnt32_d      = {bLoad_q, aLoad_q};
                    chainTimeout = 1'b1;
                end else begin
                    cnt32_d = cnt32_q - 32'h0000_0001;
                end
            end
        end
    end

    assign aTimeout = chainTimeout || halfA.timeout;
    assign bTimeout = halfB.timeout;

    // ------------------------------------------------------------
    // Enables: software write wins over hardware clear
    // ------------------------------------------------------------
    always_comb begin
        aEn_d = aEn_q;
        bEn_d = bEn_q;
        if (aTimeout && (aModeField == MODE_ONESHOT)) begin
            aEn_d = 1'b0;
        end
        if (bTimeout && (bModeField == MODE_ONESHOT)) begin
            bEn_d = 1'b0;
        end
        if (aEnableWrite) begin
            aEn_d = aEnableData;
        end
        if (bEnableWrite) begin
            bEn_d = bEnableData;
        end
    end

    // ------------------------------------------------------------
    // Status, trigger and read views; set beats clear
    // ------------------------------------------------------------
    always_comb begin
        aRaw_d = (aRaw_q && !aTimeoutClear) || aTimeout;
        bRaw_d = (bRaw_q && !bTimeoutClear) || bTimeout;
        mRaw_d = (mRaw_q && !clockMatchClear) || matchHit;
        trig_d = (aTimeout && aOutputTriggerEnable) ||
                 (bTimeout && bOutputTriggerEnable);
        aVal_d = chained ? cnt32_d : {16'h0000, halfA.count};
    end

    // ------------------------------------------------------------
    // Register only
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prevCfg_q <= CFG_CHAINED;
            aEn_q     <= 1'b0;
            bEn_q     <= 1'b0;
            aLoad_q   <= HALF_LOAD_RST;
            bLoad_q   <= HALF_LOAD_RST;
            aPre_q    <= PRESCALE_RST;
            bPre_q    <= PRESCALE_RST;
            match_q   <= MATCH_RST;
            cnt32_q   <= {HALF_LOAD_RST, HALF_LOAD_RST};
            aRaw_q    <= 1'b0;
            bRaw_q    <= 1'b0;
            mRaw_q    <= 1'b0;
            aMis_q    <= 1'b0;
            bMis_q    <= 1'b0;
            mMis_q    <= 1'b0;
            irq_q     <= 1'b0;
            trig_q    <= 1'b0;
            aVal_q    <= {HALF_LOAD_RST, HALF_LOAD_RST};
            bVal_q    <= HALF_LOAD_RST;
        end else begin
            prevCfg_q <= timerConfiguration;
            aEn_q     <= aEn_d;
            bEn_q     <= bEn_d;
            aLoad_q   <= aLoad_d;
            bLoad_q   <= bLoad_d;
            aPre_q    <= aPre_d;
            bPre_q    <= bPre_d;
            match_q   <= match_d;
            cnt32_q   <= cnt32_d;
            aRaw_q    <= aRaw_d;
            bRaw_q    <= bRaw_d;
            mRaw_q    <= mRaw_d;
            aMis_q    <= aRaw_d && aTimeoutMask;
            bMis_q    <= bRaw_d && bTimeoutMask;
            mMis_q    <= mRaw_d && clockMatchMask;
            irq_q     <= (aRaw_d && aTimeoutMask) || (bRaw_d && bTimeoutMask) ||
                         (mRaw_d && clockMatchMask);
            trig_q    <= trig_d;
            aVal_q    <= aVal_d;
            bVal_q    <= chained ? cnt32_d[31:16] : halfB.count;
        end
    end

    assign aCounterValue    = aVal_q;
    assign bCounterValue    = bVal_q;
    assign aEnable          = aEn_q;
    assign bEnable          = bEn_q;
    assign aTimeoutRaw      = aRaw_q;
    assign bTimeoutRaw      = bRaw_q;
    assign clockMatchRaw    = mRaw_q;
    assign aTimeoutMasked   = aMis_q;
    assign bTimeoutMasked   = bMis_q;
    assign clockMatchMasked = mMis_q;
    assign interruptOut     = irq_q;
    assign adcTrigger       = trig_q;

endmodule
`default_nettype wire

/* File: testbench/gptp_monitor.sv */
// Purpose: Port-level temporal checks of the timer pair.
// Assumes: Bound onto gptp_timer_pair, one clock domain.
// Notes:   Status and trigger outputs are registered together.
`timescale 1ns/100ps
`default_nettype none
module gptp_monitor (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [2:0]  timerConfiguration,
    input wire logic        aEnableWrite,
    input wire logic        aOutputTriggerEnable,
    input wire logic        aTimeoutClear,
    input wire logic [31:0] aCounterValue,
    input wire logic        aEnable,
    input wire logic        aTimeoutRaw,
    input wire logic        aTimeoutMasked,
    input wire logic        bTimeoutMasked,
    input wire logic        clockMatchRaw,
    input wire logic        clockMatchMasked,
    input wire logic        interruptOut,
    input wire logic        adcTrigger
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_mask_gate: assert property (aTimeoutMasked |-> aTimeoutRaw)
        else $error("masked time-out without raw");
    a_raw_sticky: assert property (aTimeoutRaw && !aTimeoutClear |=> aTimeoutRaw)
        else $error("time-out status lost");
    a_irq_or: assert property (interruptOut == (aTimeoutMasked | bTimeoutMasked
        | clockMatchMasked)) else $error("interrupt not the masked OR");
    a_trig_gate: assert property (timerConfiguration == 3'h0 && adcTrigger
        |-> $past(aOutputTriggerEnable) && aTimeoutRaw) else $error("bad trigger");
    a_trig_pulse: assert property (adcTrigger |=> !adcTrigger)
        else $error("trigger wider than one cycle");
    a_oneshot_stop: assert property ($fell(aEnable) && !$past(aEnableWrite)
        |-> aTimeoutRaw) else $error("enable dropped without time-out");
    a_rtc_mask: assert property (clockMatchMasked |-> clockMatchRaw)
        else $error("masked match without raw");
    a_rtc_zero: assert property ($rose(clockMatchRaw)
        |-> aCounterValue == 32'h0000_0000) else $error("match did not roll to zero");
endmodule
`default_nettype wire

/* File: testbench/tb_gptp_timer_pair.sv */
// Purpose: Directed test of the timer pair at its ports.
// Assumes: Clock-mode divide shortened to four pin edges.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none
module tb_gptp_timer_pair;
    import gptp_pkg::*;
    localparam int EDGES = 4; // Short divide keeps the run brief
    logic clk_sys, reset, aEnableWrite, aEnableData, bEnableWrite, bEnableData;
    logic aIntervalWrite, bIntervalWrite, aPrescaleWrite, bPrescaleWrite, aMatchWrite;
    logic aOutputTriggerEnable, bOutputTriggerEnable, aDebugStall, bDebugStall;
    logic clockModeEnable, aTimeoutMask, bTimeoutMask, clockMatchMask, cpuHalted;
    logic aTimeoutClear, bTimeoutClear, clockMatchClear, capturePinEven;
    logic [2:0] timerConfiguration;
    logic [1:0] aModeField, bModeField;
    logic [31:0] aIntervalData, aMatchData, aCounterValue, v;
    logic [15:0] bIntervalData, bCounterValue;
    logic [7:0] prescaleData;
    logic aEnable, bEnable, aTimeoutRaw, bTimeoutRaw, clockMatchRaw, adcTrigger;
    logic aTimeoutMasked, bTimeoutMasked, clockMatchMasked, interruptOut;
    int n_mismatch = 0, cmp_count = 0, n;
    gptp_timer_pair #(.RTC_EDGES(EDGES)) dut (.*);
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // One-cycle strobe, never re-raised at the same edge
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task automatic waitfor(ref logic f);
        for (n = 0; f !== 1'b1; n++) begin
            cyc(1);
            if (n > 400) begin
                n_mismatch++;
                results();
            end
        end
    endtask
    // Slow pin clock, still between bursts
    task automatic pin(input int k);
        repeat (k) begin
            capturePinEven = 1;
            cyc(4);
            capturePinEven = 0;
            cyc(4);
        end
        cyc(6);
    endtask
    task automatic step(output int k);
        v[15:0] = bCounterValue;
        for (k = 0; k < 50 && bCounterValue === v[15:0]; k++) cyc(1);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {aEnableWrite, aEnableData, bEnableWrite, bEnableData, aIntervalWrite} = '0;
        {bIntervalWrite, aPrescaleWrite, bPrescaleWrite, aMatchWrite, aDebugStall} = '0;
        {bOutputTriggerEnable, bDebugStall, clockModeEnable, aTimeoutMask} = '0;
        {bTimeoutMask, clockMatchMask, cpuHalted, aTimeoutClear, bTimeoutClear} = '0;
        {clockMatchClear, capturePinEven, aIntervalData, aMatchData, bIntervalData} = '0;
        {timerConfiguration, bModeField, prescaleData} = '0;
        aModeField = MODE_ONESHOT;
        aOutputTriggerEnable = 1;
        reset = 1;
        cyc(8);
        reset = 0;
        chk(aCounterValue, 32'hFFFF_FFFF); chk(bCounterValue, HALF_LOAD_RST);
        aIntervalData = 32'h0000_0003;
        pulse(aIntervalWrite);
        aEnableData = 1;
        pulse(aEnableWrite);
        waitfor(aTimeoutRaw);
        // Four edges from enable: three decrements to zero, then the reload edge
        chk(n, 4); chk(aEnable, 0); chk(aCounterValue, 3);
        chk(adcTrigger, 1);
        pulse(aTimeoutClear);
        chk(aTimeoutRaw, 0);
        $display("chained one-shot done");
        {aModeField, bModeField, aTimeoutMask} = {MODE_PERIODIC, MODE_ONESHOT, 1'b1};
        pulse(aEnableWrite);
        waitfor(aTimeoutRaw);
        pulse(aTimeoutClear);
        waitfor(aTimeoutRaw);
        chk(aEnable, 1); chk(aTimeoutMasked, 1); chk(interruptOut, 1);
        aIntervalData = 32'h0002_0180;
        pulse(aIntervalWrite);
        cyc(2);
        chk(aCounterValue[31:8], 32'h0000_0201);
        chk(bCounterValue, 16'h0002);
        {aDebugStall, cpuHalted} = 2'b11;
        cyc(2);
        v = aCounterValue;
        cyc(5);
        chk(aCounterValue, v);
        cpuHalted = 0;
        cyc(3);
        chk(aCounterValue !== v, 1);
        aEnableData = 0;
        pulse(aEnableWrite);
        $display("chained periodic done");
        timerConfiguration = CFG_CLOCK;
        cyc(3);
        chk(aCounterValue, CLOCK_FIRST);
        aMatchData = 32'h0000_0002;
        pulse(aMatchWrite);
        cyc(2);
        chk(aCounterValue, 2);
        {clockModeEnable, clockMatchMask, cpuHalted, aEnableData} = 4'hF;
        pulse(aEnableWrite);
        pin(EDGES);
        chk(aCounterValue, 0); chk(clockMatchMasked, 1);
        pin(EDGES - 1);
        chk(aCounterValue, 0);
        pin(1);
        chk(aCounterValue, 1);
        pulse(clockMatchClear);
        chk({clockMatchRaw, clockMatchMasked}, 0);
        aEnableData = 0;
        pulse(aEnableWrite);
        $display("clock mode done");
        {timerConfiguration, cpuHalted, prescaleData} = {CFG_SPLIT, 1'b0, 8'h02};
        pulse(bPrescaleWrite);
        bIntervalData = 16'h0005;
        pulse(bIntervalWrite);
        bEnableData = 1;
        pulse(bEnableWrite);
        step(n);
        step(n);
        chk(n, 3);
        waitfor(bTimeoutRaw);
        chk(bEnable, 0); chk(adcTrigger, 0); chk(bTimeoutMasked, 0);
        // Split read view trails the half counter by one edge
        cyc(1);
        chk(bCounterValue, 16'h0005);
        $display("split mode done");
        results();
    end
endmodule
bind gptp_timer_pair gptp_monitor mon (.*);
`default_nettype wire
